// >>> hdl/chs_consts.svh
// Constants of the charger supervisor: offsets, field positions, reset values and timing figures.
`ifndef CHS_CONSTS_SVH
`define CHS_CONSTS_SVH
// Clock period and time units in nanoseconds and microseconds.
`define CHS_CLK_NS 10
`define CHS_NS_PER_US 1000
`define CHS_US_PER_MS 1000
// Register offsets on the plain register port.
`define CHS_A_CTRL 8'h00
`define CHS_A_TIME 8'h04
`define CHS_A_EVEN 8'h08
`define CHS_A_CHGI 8'h0c
`define CHS_A_CHGV 8'h10
`define CHS_A_STAT 8'h14
// Control register bit positions.
`define CHS_C_PK_SYS 0
`define CHS_C_PK_IIN 1
`define CHS_C_EXT 2
`define CHS_C_CLR 3
`define CHS_C_LPM 4
`define CHS_C_LPA 5
`define CHS_C_OCP_EN 6
`define CHS_C_OCP_SEL 7
`define CHS_C_FL_LOW 8
`define CHS_C_FL_RNG 9
`define CHS_C_WD_LO 10
`define CHS_C_FL_EN 12
// Control reset value: watchdog period select 11b, everything else off.
`define CHS_CTRL_RST 13'h0c00
// Timing register fields and their reset value.
`define CHS_OVERLOAD_DURATION_LO 0
`define CHS_T_TMAX_LO 2
`define CHS_T_PW_LO 4
`define CHS_TIME_RST 6'h3f
// Status register bit positions.
`define CHS_S_FLOOR 8
`define CHS_S_EXIT 9
`define CHS_S_OVP 10
`define CHS_S_OCP 11
`define CHS_S_PK 12
`define CHS_S_SUSP 13
`define CHS_S_WD 14
// Selectable times in milliseconds for each two-bit select.
`define CHS_OVLD_MS {16'd20, 16'd10, 16'd2, 16'd1}
`define CHS_TMAX_MS {16'd40, 16'd20, 16'd10, 16'd5}
`define CHS_PW_MS {16'd10, 16'd5, 16'd2, 16'd1}
`define CHS_WD_MS {32'd175000, 32'd88000, 32'd44000, 32'd0}
// Deglitch figures.
`define CHS_OVP_RISE_US 100
`define CHS_OVP_FALL_US 1000
`define CHS_OCP_RISE_US 250
`define CHS_OCP_FALL_MS 250
`endif

// >>> hdl/chs_pkg.sv
// Types shared by the charger supervisor.
`default_nettype none
package chs_pkg;
  // Comparator results from the analog front end, all active high.
  typedef struct packed {
    logic sys_under;     // System voltage below the minimum system voltage.
    logic iin_over_lim1; // Input current above the level-one limit.
    logic peak_ev;       // Input current above 110 percent of the level-two limit.
    logic avg_ev;        // Input current above 110 percent of the input limit setting.
    logic dis1_ev;       // Discharge current level one.
    logic dis2_ev;       // Discharge current level two.
    logic adapter_low;   // Input supply voltage below the 3.2 V adapter threshold.
    logic batt_pin;      // Battery presence pin level.
    logic cmp_out;       // Independent comparator output level.
    logic floor_100;     // Input voltage below 100 percent of the floor.
    logic floor_91;      // Input voltage below 91 percent of the floor.
    logic floor_83;      // Input voltage below 83 percent of the floor.
    logic assist_exit;   // Exit from assist mode.
    logic cmp_below_1v2; // Comparator input below the fixed 1.2 V threshold.
    logic ovp_rise;      // Input supply above the overvoltage rising threshold.
    logic ovp_fall;      // Input supply below the overvoltage falling threshold.
    logic oc_133;        // Input current above 1.33 times the level-two setting.
    logic oc_200;        // Input current above 2 times the level-two setting.
  } chs_sense_t;
  // One request on the register port.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } chs_bus_t;
  // Peak power sequencer states.
  typedef enum logic [1:0] {PK_IDLE, PK_LVL2, PK_LVL1} chs_pk_t;
endpackage
`default_nettype wire

// >>> hdl/chs_supervisor.sv
// Charger supervisor: peak power sequencer, hot alert, watchdog and input faults.
//
// Added by the designer: the register addresses and strobed register access.
`default_nettype none
`include "chs_consts.svh"
// Summary of operation
// - Level two for overload time, then level one.
// - New cycle at cycle end if trigger persists.
// - Suspend charging after overload time until next cycle.
// - System undershoot triggers peak power when enabled.
// - Input overshoot triggers peak power when enabled.
// - Adapter peak and average current events.
// - Adapter removal, battery removal, comparator falling events.
// - Floor threshold chosen by lower and range bits.
// - Assist exit always on; others need enables.
// - Alert pulse of minimum width, extended while active.
// - Extension mode holds alert until clear written.
// - Floor and assist exit hold until status cleared.
// - Low power alert when comparator below 1.2 V.
// - Status sticky; read clears only inactive events in bits 0 to 7, floor and exit by write.
// - Several events set all bits, extend pulse.
// - Watchdog expiry zeroes only the charge current.
// - Charge writes and period writes restart watchdog.
// - Overvoltage deglitched 100 us, recovers after 1 ms.
// - Overcurrent stops switching, 250 us in, 250 ms out.
// - Overcurrent off at reset, read-cleared fault bit.
module chs_supervisor #(
  parameter int CYC_PER_US = `CHS_NS_PER_US / `CHS_CLK_NS, // Cycles per microsecond tick.
  parameter int US_PER_MS = `CHS_US_PER_MS                  // Microsecond ticks per millisecond tick.
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire chs_pkg::chs_bus_t bus,
  output logic [31:0] rdata,
  input wire chs_pkg::chs_sense_t sense,
  output logic cpu_hot_alert_n,
  output logic charge_ok_out,
  output logic converter_en,
  output logic limit_lvl2_sel,
  output logic charge_en,
  output logic [15:0] charge_current_setting,
  output logic [15:0] charge_voltage_setting
);
  // ****************************************************************
  // Input synchronisers and prescaler
  // ****************************************************************
  chs_pkg::chs_sense_t s1_q, s_q, sp_q; // First stage, second stage, previous value.
  logic [6:0] pre_q;                    // Cycle prescaler.
  logic [9:0] usc_q;                    // Microsecond prescaler.
  logic tick_us, tick_ms;
  // Two flip-flops before any logic looks at the comparators.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_q <= '0;
      s_q <= '0;
      sp_q <= '0;
    end else begin
      s1_q <= sense;
      s_q <= s1_q;
      sp_q <= s_q;
    end
  end
  assign tick_us = (pre_q == 7'(CYC_PER_US - 1));
  assign tick_ms = tick_us && (usc_q == 10'(US_PER_MS - 1));
  // Prescaler producing microsecond and millisecond ticks.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_q <= '0;
      usc_q <= '0;
    end else begin
      pre_q <= tick_us ? 7'h00 : pre_q + 7'h01;
      if (tick_us) begin
        usc_q <= tick_ms ? 10'h000 : usc_q + 10'h001;
      end
    end
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [12:0] ctrl_q;  // Control bits.
  logic [5:0] time_q;   // Overload, cycle and pulse width selects.
  logic [7:0] even_q;   // Hot event enable field.
  logic [15:0] chgi_q, chgv_q;
  logic [9:0] stat_q;   // Event status bits.
  logic ovp_q, ocp_act_q, ocp_flt_q, wd_exp_q;
  logic wr_ctrl, wr_chg, rd_stat, wd_fire;
  logic [9:0] act;      // Enabled events that are active now.
  assign wr_ctrl = bus.wr && (bus.addr == `CHS_A_CTRL);
  assign wr_chg = bus.wr && ((bus.addr == `CHS_A_CHGI) || (bus.addr == `CHS_A_CHGV));
  assign rd_stat = bus.rd && (bus.addr == `CHS_A_STAT);
  // Plain configuration writes.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= `CHS_CTRL_RST;
      time_q <= `CHS_TIME_RST;
      even_q <= 8'h00;
      chgv_q <= 16'h0000;
    end else if (bus.wr) begin
      if (bus.addr == `CHS_A_CTRL) begin
        ctrl_q <= bus.wdata[12:0];
      end else if (bus.addr == `CHS_A_TIME) begin
        time_q <= bus.wdata[5:0];
      end else if (bus.addr == `CHS_A_EVEN) begin
        even_q <= bus.wdata[7:0];
      end else if (bus.addr == `CHS_A_CHGV) begin
        chgv_q <= bus.wdata[15:0];
      end
    end
  end
  // Charge current: the watchdog expiry zeroes it, a host write wins.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chgi_q <= 16'h0000;
    end else if (bus.wr && (bus.addr == `CHS_A_CHGI)) begin
      chgi_q <= bus.wdata[15:0];
    end else if (wd_fire) begin
      chgi_q <= 16'h0000;
    end
  end
  // Read data stands in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      if (bus.addr == `CHS_A_CTRL) begin
        rdata <= {19'h00000, ctrl_q};
      end else if (bus.addr == `CHS_A_TIME) begin
        rdata <= {26'h0000000, time_q};
      end else if (bus.addr == `CHS_A_EVEN) begin
        rdata <= {24'h000000, even_q};
      end else if (bus.addr == `CHS_A_CHGI) begin
        rdata <= {16'h0000, chgi_q};
      end else if (bus.addr == `CHS_A_CHGV) begin
        rdata <= {16'h0000, chgv_q};
      end else if (bus.addr == `CHS_A_STAT) begin
        rdata <= {17'h00000, wd_exp_q, !charge_en, limit_lvl2_sel, ocp_flt_q, ovp_q, stat_q};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end
  end
  // ****************************************************************
  // Peak power sequencer
  // ****************************************************************
  localparam logic [63:0] OVLD_MS = `CHS_OVLD_MS;
  localparam logic [63:0] TMAX_MS = `CHS_TMAX_MS;
  chs_pkg::chs_pk_t pk_q;
  logic [19:0] pk_us_q; // Microseconds since the cycle began.
  logic pk_trig;
  logic [19:0] ovld_us, tmax_us;
  assign pk_trig = (ctrl_q[`CHS_C_PK_SYS] && s_q.sys_under)
                || (ctrl_q[`CHS_C_PK_IIN] && s_q.iin_over_lim1);
  assign ovld_us = 20'(OVLD_MS[16*time_q[1:0] +: 16] * US_PER_MS);
  assign tmax_us = 20'(TMAX_MS[16*time_q[3:2] +: 16] * US_PER_MS);
  // Level two, then level one, then either restart or go idle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pk_q <= chs_pkg::PK_IDLE;
      pk_us_q <= '0;
    end else begin
      case (pk_q)
        chs_pkg::PK_IDLE: begin
          pk_us_q <= '0;
          if (pk_trig) begin
            pk_q <= chs_pkg::PK_LVL2;
          end
        end
        chs_pkg::PK_LVL2: begin
          pk_us_q <= pk_us_q + 20'(tick_us);
          if (pk_us_q >= ovld_us) begin
            pk_q <= chs_pkg::PK_LVL1;
          end
        end
        default: begin
          pk_us_q <= pk_us_q + 20'(tick_us);
          if (pk_us_q >= tmax_us) begin
            pk_us_q <= '0;
            pk_q <= pk_trig ? chs_pkg::PK_LVL2 : chs_pkg::PK_IDLE;
          end
        end
      endcase
    end
  end
  assign limit_lvl2_sel = (pk_q == chs_pkg::PK_LVL2);
  // Charging is held off for the rest of a cycle once level two has ended.
  assign charge_en = (pk_q != chs_pkg::PK_LVL1) && (chgi_q != 16'h0000) && converter_en;
  // ****************************************************************
  // Hot events, status and alert
  // ****************************************************************
  localparam logic [63:0] PW_MS = `CHS_PW_MS;
  logic floor_ev;
  logic [19:0] pw_q;  // Remaining pulse time in microseconds.
  logic ext_q, lp_alert;
  // Floor threshold select.
  assign floor_ev = !ctrl_q[`CHS_C_FL_LOW] ? s_q.floor_100 :
                    (ctrl_q[`CHS_C_FL_RNG] ? s_q.floor_91 : s_q.floor_83);
  // Edge events last one cycle: removal rising, battery pin and comparator falling.
  assign act[7:0] = even_q & {s_q.sys_under, sp_q.cmp_out && !s_q.cmp_out,
                               sp_q.batt_pin && !s_q.batt_pin, s_q.adapter_low && !sp_q.adapter_low,
                               s_q.dis2_ev, s_q.dis1_ev, s_q.avg_ev, s_q.peak_ev};
  assign act[`CHS_S_FLOOR] = ctrl_q[`CHS_C_FL_EN] && floor_ev;
  assign act[`CHS_S_EXIT] = s_q.assist_exit;
  // Status bits: every active event sets its bit, set wins over clear.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < 10; i++) begin
        if (act[i]) begin
          stat_q[i] <= 1'b1;
        end else if (i < 8 && rd_stat) begin
          stat_q[i] <= 1'b0;
        end else if (i >= 8 && bus.wr && bus.addr == `CHS_A_STAT && !bus.wdata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end
  // Minimum pulse timer restarted by any enabled event.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pw_q <= '0;
    end else if (|act) begin
      pw_q <= 20'(PW_MS[16*time_q[5:4] +: 16] * US_PER_MS);
    end else if (tick_us && pw_q != 20'h00000) begin
      pw_q <= pw_q - 20'h00001;
    end
  end
  // Extension latch: cleared by writing 0 to the clear bit, a new trigger wins.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_q <= 1'b0;
    end else if (ctrl_q[`CHS_C_EXT] && |act) begin
      ext_q <= 1'b1;
    end else if (wr_ctrl && !bus.wdata[`CHS_C_CLR]) begin
      ext_q <= 1'b0;
    end
  end
  assign lp_alert = ctrl_q[`CHS_C_LPM] && ctrl_q[`CHS_C_LPA] && s_q.cmp_below_1v2;
  // Alert pin: pulse, active events, extension, low power alert and the two held status bits.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_hot_alert_n <= 1'b1;
    end else begin
      cpu_hot_alert_n <= !((pw_q != 20'h00000) || (|act) || ext_q || lp_alert
                         || stat_q[`CHS_S_FLOOR] || stat_q[`CHS_S_EXIT]);
    end
  end
  // ****************************************************************
  // Watchdog
  // ****************************************************************
  localparam logic [127:0] WD_MS = `CHS_WD_MS;
  logic [31:0] wd_q; // Milliseconds since the last restart.
  logic [1:0] wd_sel;
  assign wd_sel = ctrl_q[`CHS_C_WD_LO +: 2];
  assign wd_fire = (wd_sel != 2'b00) && (wd_q >= WD_MS[32*wd_sel +: 32]) && !wd_exp_q && !wr_ctrl && !wr_chg;
  // Counts milliseconds; charge or period writes restart it, 00b stops it.
  always_ff @(posedge sys_clk) begin
    if (srst || wr_ctrl || wr_chg || wd_sel == 2'b00) begin
      wd_q <= '0;
    end else if (tick_ms && !wd_exp_q) begin
      wd_q <= wd_q + 32'h0000_0001;
    end
  end
  // Expiry flag, held until the watchdog is restarted.
  always_ff @(posedge sys_clk) begin
    if (srst || wr_ctrl || wr_chg) begin
      wd_exp_q <= 1'b0;
    end else if (wd_fire) begin
      wd_exp_q <= 1'b1;
    end
  end
  // ****************************************************************
  // Input overvoltage and overcurrent
  // ****************************************************************
  logic [9:0] ovc_q, occ_q; // Deglitch counters in microseconds or milliseconds.
  logic oc_cond;
  // Overvoltage: rising deglitch in microseconds, falling deglitch in microseconds.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovp_q <= 1'b0;
      ovc_q <= '0;
    end else if (!ovp_q ? !s_q.ovp_rise : !s_q.ovp_fall) begin
      ovc_q <= '0;
    end else if (tick_us) begin
      ovc_q <= ovc_q + 10'h001;
      if (!ovp_q && ovc_q >= 10'(`CHS_OVP_RISE_US)) begin
        ovp_q <= 1'b1;
        ovc_q <= '0;
      end else if (ovp_q && ovc_q >= 10'(`CHS_OVP_FALL_US)) begin
        ovp_q <= 1'b0;
        ovc_q <= '0;
      end
    end
  end
  assign oc_cond = ctrl_q[`CHS_C_OCP_EN] && (ctrl_q[`CHS_C_OCP_SEL] ? s_q.oc_200 : s_q.oc_133);
  // Overcurrent: 250 us to trip, 250 ms to recover; disabling ends it at once.
  always_ff @(posedge sys_clk) begin
    if (srst || !ctrl_q[`CHS_C_OCP_EN]) begin
      ocp_act_q <= 1'b0;
      occ_q <= '0;
    end else if (ocp_act_q == oc_cond) begin
      occ_q <= '0;
    end else if (!ocp_act_q ? tick_us : tick_ms) begin
      occ_q <= occ_q + 10'h001;
      if (!ocp_act_q && occ_q >= 10'(`CHS_OCP_RISE_US)) begin
        ocp_act_q <= 1'b1;
        occ_q <= '0;
      end else if (ocp_act_q && occ_q >= 10'(`CHS_OCP_FALL_MS)) begin
        ocp_act_q <= 1'b0;
        occ_q <= '0;
      end
    end
  end
  // Fault bit: set on trip, cleared by a status read, set wins.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ocp_flt_q <= 1'b0;
    end else if (oc_cond && !ocp_act_q && tick_us && occ_q >= 10'(`CHS_OCP_RISE_US)) begin
      ocp_flt_q <= 1'b1;
    end else if (rd_stat) begin
      ocp_flt_q <= 1'b0;
    end
  end
  // Charge-ok goes low while the overvoltage flag stands.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      charge_ok_out <= 1'b1;
    end else begin
      charge_ok_out <= !ovp_q;
    end
  end
  assign converter_en = !ovp_q && !ocp_act_q;
  assign charge_current_setting = chgi_q;
  assign charge_voltage_setting = chgv_q;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ovp_ok;
    @(posedge sys_clk) disable iff (srst) $rose(ovp_q) |=> !charge_ok_out && !converter_en;
  endproperty
  a_ovp_ok: assert property (p_ovp_ok) else $error("charge ok not low on overvoltage");
  property p_ocp_off;
    @(posedge sys_clk) disable iff (srst) !ctrl_q[`CHS_C_OCP_EN] |=> !ocp_act_q;
  endproperty
  a_ocp_off: assert property (p_ocp_off) else $error("overcurrent active while disabled");
  property p_pk_start;
    @(posedge sys_clk) disable iff (srst) (pk_q == chs_pkg::PK_IDLE && pk_trig) |=> limit_lvl2_sel;
  endproperty
  a_pk_start: assert property (p_pk_start) else $error("peak cycle did not start");
  property p_susp;
    @(posedge sys_clk) disable iff (srst) $fell(limit_lvl2_sel) && pk_q == chs_pkg::PK_LVL1 |-> !charge_en;
  endproperty
  a_susp: assert property (p_susp) else $error("charging not suspended after overload");
  property p_wd;
    @(posedge sys_clk) disable iff (srst) wd_fire && !(bus.wr && bus.addr == `CHS_A_CHGI)
      |=> chgi_q == 16'h0000 && wd_exp_q;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog expiry kept charge current");
  property p_alert;
    @(posedge sys_clk) disable iff (srst) |act |=> !cpu_hot_alert_n ##1 (pw_q != 20'h00000);
  endproperty
  a_alert: assert property (p_alert) else $error("alert pulse missing");
  property p_stat;
    @(posedge sys_clk) disable iff (srst) act[0] |=> stat_q[0];
  endproperty
  a_stat: assert property (p_stat) else $error("status bit not set");
  property p_hold;
    @(posedge sys_clk) disable iff (srst) stat_q[`CHS_S_EXIT] |=> !cpu_hot_alert_n;
  endproperty
  a_hold: assert property (p_hold) else $error("alert released while exit status set");
  property p_lp;
    @(posedge sys_clk) disable iff (srst) lp_alert |=> !cpu_hot_alert_n;
  endproperty
  a_lp: assert property (p_lp) else $error("low power alert missing");
  c_restart: cover property (@(posedge sys_clk) pk_q == chs_pkg::PK_LVL1 ##1 pk_q == chs_pkg::PK_LVL2);
  c_ovp: cover property (@(posedge sys_clk) $rose(ovp_q));
  c_wd: cover property (@(posedge sys_clk) wd_fire);
  c_ext: cover property (@(posedge sys_clk) ext_q && act == 10'h000);
endmodule // chs_supervisor
`default_nettype wire

// >>> tb/chs_cpu_model.sv
// CPU side model that times each low run of the hot alert line.
`default_nettype none
module chs_cpu_model (
  input wire logic sys_clk,
  input wire logic cpu_hot_alert_n,
  output logic [15:0] low_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q = 1'b1; // Alert level seen at the previous edge.
  // A fresh low run restarts the count from one, so each pulse is timed alone.
  always_ff @(posedge sys_clk) begin
    if (cpu_hot_alert_n === 1'b0 && prev_q === 1'b1) begin
      low_len <= 16'h0001;
    end else if (cpu_hot_alert_n === 1'b0) begin
      low_len <= low_len + 16'h0001;
    end
    prev_q <= cpu_hot_alert_n;
  end
endmodule // chs_cpu_model
`default_nettype wire

// >>> tb/chs_supervisor_test.sv
// Self-checking bench of the charger supervisor.
`default_nettype none
`include "chs_consts.svh"
module chs_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Stimulus, design and CPU model.
  // ************************************************************
  logic sys_clk = 1'b0; // Clock at 100 MHz.
  logic srst = 1'b1; // Synchronous reset.
  chs_pkg::chs_bus_t bus = '0; // Register port request.
  chs_pkg::chs_sense_t sense = '0; // Comparator levels.
  logic [31:0] rdata, q;
  logic cpu_hot_alert_n, charge_ok_out, converter_en, limit_lvl2_sel, charge_en;
  logic [15:0] charge_current_setting, charge_voltage_setting, low_len;
  logic [15:0] wd_chgi; // Charge current of the fast watchdog instance.
  int errors = 0;
  int num_checks = 0;
  int n;
  chs_supervisor #(.CYC_PER_US(2), .US_PER_MS(4)) i_chs_supervisor (.sys_clk(sys_clk), .srst(srst), .bus(bus),
    .rdata(rdata), .sense(sense), .cpu_hot_alert_n(cpu_hot_alert_n), .charge_ok_out(charge_ok_out),
    .converter_en(converter_en), .limit_lvl2_sel(limit_lvl2_sel), .charge_en(charge_en),
    .charge_current_setting(charge_current_setting), .charge_voltage_setting(charge_voltage_setting));
  chs_cpu_model i_chs_cpu_model (.sys_clk(sys_clk), .cpu_hot_alert_n(cpu_hot_alert_n), .low_len(low_len));
  // A millisecond per cycle so that the shortest watchdog period fits the run.
  chs_supervisor #(.CYC_PER_US(1), .US_PER_MS(1)) i_chs_supervisor_wd (.sys_clk(sys_clk), .srst(srst), .bus(bus),
    .rdata(), .sense('0), .cpu_hot_alert_n(), .charge_ok_out(), .converter_en(), .limit_lvl2_sel(), .charge_en(),
    .charge_current_setting(wd_chgi), .charge_voltage_setting());
  // Clock toggles every half period.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ************************************************************
  // Shared tasks.
  // ************************************************************
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is taken in the cycle after it.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Waits for the alert to rise, at most the given cycles.
  task automatic wait_alert_high(input int lim);
    for (n = 0; n < lim && cpu_hot_alert_n !== 1'b1; n++) @(posedge sys_clk);
  endtask
  // ************************************************************
  // Scenarios.
  // ************************************************************
  // Reset values, unmapped read and a charge current write.
  task automatic t_reset;
    rd(`CHS_A_CTRL, q); chk(q === 32'h0000_0c00, "ctrl reset");
    rd(`CHS_A_TIME, q); chk(q === 32'h0000_003f, "time reset");
    rd(`CHS_A_EVEN, q); chk(q === 32'h0, "enable reset");
    rd(8'h3c, q); chk(q === 32'h0, "unmapped read");
    chk(cpu_hot_alert_n === 1'b1 && charge_ok_out === 1'b1, "outputs after reset");
    wr(`CHS_A_CHGI, 32'h0000_0005);
    #1 chk(charge_current_setting === 16'h0005, "charge current write");
  endtask
  // Enabled event gives a 1 ms pulse and a read-clear status; a disabled one stays silent.
  task automatic t_pulse;
    wr(`CHS_A_TIME, 32'h0000_000c);
    wr(`CHS_A_EVEN, 32'h0000_0001);
    @(posedge sys_clk) sense.avg_ev <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(cpu_hot_alert_n === 1'b1, "disabled event alerted");
    sense.avg_ev <= 1'b0;
    sense.peak_ev <= 1'b1;
    @(posedge sys_clk) sense.peak_ev <= 1'b0;
    repeat (5) @(posedge sys_clk);
    wait_alert_high(100);
    chk(low_len >= 16'h0007 && low_len <= 16'h000c, "pulse width");
    rd(`CHS_A_STAT, q); chk(q[0] === 1'b1, "event status set");
    rd(`CHS_A_STAT, q); chk(q[0] === 1'b0, "event status read clear");
  endtask
  // Assist exit holds the alert until its status is written to zero.
  task automatic t_assist;
    @(posedge sys_clk) sense.assist_exit <= 1'b1;
    @(posedge sys_clk) sense.assist_exit <= 1'b0;
    repeat (100) @(posedge sys_clk);
    chk(cpu_hot_alert_n === 1'b0, "assist exit hold");
    rd(`CHS_A_STAT, q); chk(q[`CHS_S_EXIT] === 1'b1, "assist status");
    wr(`CHS_A_STAT, 32'h0);
    wait_alert_high(6);
    chk(cpu_hot_alert_n === 1'b1, "assist clear");
  endtask
  // Extension mode, low power alert and the floor threshold select.
  task automatic t_modes;
    wr(`CHS_A_CTRL, 32'h0000_0c04);
    @(posedge sys_clk) sense.peak_ev <= 1'b1;
    @(posedge sys_clk) sense.peak_ev <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk(cpu_hot_alert_n === 1'b0, "extension hold");
    wr(`CHS_A_CTRL, 32'h0000_0c30);
    wait_alert_high(6);
    chk(cpu_hot_alert_n === 1'b1, "extension clear");
    sense.cmp_below_1v2 <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(cpu_hot_alert_n === 1'b0, "low power alert");
    sense.cmp_below_1v2 <= 1'b0;
    wr(`CHS_A_CTRL, 32'h0000_1f00);
    sense.floor_83 <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(cpu_hot_alert_n === 1'b1, "floor below 83 percent only");
    sense.floor_91 <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(cpu_hot_alert_n === 1'b0, "floor below 91 percent");
    sense.floor_91 <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wr(`CHS_A_STAT, 32'h0);
    wait_alert_high(20);
    chk(cpu_hot_alert_n === 1'b1, "floor status clear");
  endtask
  // Watchdog on the fast instance: expiry zeroes the charge current, a new write resumes; the voltage is checked on the main instance.
  task automatic t_wdog;
    wr(`CHS_A_CHGV, 32'h0000_1234);
    wr(`CHS_A_CTRL, 32'h0000_0400);
    for (n = 0; n < 44100 && wd_chgi !== 16'h0000; n++) @(posedge sys_clk);
    chk(n >= 43990 && n <= 44010, "watchdog period");
    #1 chk(charge_voltage_setting === 16'h1234, "charge voltage write");
    wr(`CHS_A_CHGI, 32'h0000_0007);
    #1 chk(wd_chgi === 16'h0007, "charge current after expiry");
  endtask
  // Level two for the overload time, then level one with charging held off.
  task automatic t_peak;
    wr(`CHS_A_TIME, 32'h0000_0000);
    wr(`CHS_A_CTRL, 32'h0000_0c02);
    @(posedge sys_clk) sense.iin_over_lim1 <= 1'b1;
    for (n = 0; n < 10 && limit_lvl2_sel !== 1'b1; n++) @(posedge sys_clk);
    for (n = 0; n < 30 && limit_lvl2_sel === 1'b1; n++) @(posedge sys_clk);
    chk(n >= 6 && n <= 11, "level two duration");
    #1 chk(charge_en === 1'b0, "charging held in level one");
    sense.iin_over_lim1 <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(charge_en === 1'b1 && limit_lvl2_sel === 1'b0, "charging resumed");
  endtask
  // Overcurrent ignored while off, then trips after 250 us and recovers after 250 ms.
  task automatic t_ocp;
    @(posedge sys_clk) sense.oc_133 <= 1'b1;
    repeat (600) @(posedge sys_clk);
    chk(converter_en === 1'b1, "overcurrent while off");
    wr(`CHS_A_CTRL, 32'h0000_0c40);
    for (n = 0; n < 700 && converter_en === 1'b1; n++) @(posedge sys_clk);
    chk(n >= 490 && n <= 520, "overcurrent rise deglitch");
    rd(`CHS_A_STAT, q); chk(q[`CHS_S_OCP] === 1'b1, "overcurrent status");
    sense.oc_133 <= 1'b0;
    for (n = 0; n < 2200 && converter_en !== 1'b1; n++) @(posedge sys_clk);
    chk(n >= 1990 && n <= 2020, "overcurrent fall deglitch");
  endtask
  // Overvoltage trips after 100 us and recovers after 1 ms.
  task automatic t_ovp;
    @(posedge sys_clk) sense.ovp_fall <= 1'b0;
    sense.ovp_rise <= 1'b1;
    for (n = 0; n < 300 && charge_ok_out === 1'b1; n++) @(posedge sys_clk);
    chk(n >= 198 && n <= 210 && converter_en === 1'b0, "overvoltage trip");
    sense.ovp_rise <= 1'b0;
    sense.ovp_fall <= 1'b1;
    for (n = 0; n < 2200 && charge_ok_out !== 1'b1; n++) @(posedge sys_clk);
    chk(n >= 1998 && n <= 2010, "overvoltage recovery");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence after four reset cycles.
  initial begin
    sense.batt_pin = 1'b1;
    sense.cmp_out = 1'b1;
    sense.ovp_fall = 1'b1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_pulse();
    t_assist();
    t_peak();
    t_ocp();
    t_ovp();
    t_modes();
    t_wdog();
    finish_test();
  end
  // Watchdog well beyond the expected fifty thousand cycles.
  initial begin
    #800us;
    errors++;
    finish_test();
  end
endmodule // chs_supervisor_test
`default_nettype wire
